/* common/ssp_consts.svh */
// Constants for the serial port control and two-wire master sequencer.
// Assumes a 32-bit APB slave, one word per register, byte addresses below.
// What this block does
// - Byte arriving into full buffer sets overflow, except in SPI master modes.
// - Enable bit hands clock/data pins to port.
// - SPI clock idles at polarity bit level.
// - Two-wire slave: polarity zero stretches clock low.
// - Modes 0000/0001/0010: SPI master, divide 4/16/64.
// - Mode 0101: SPI slave, select pin unused.
// - Modes 0111/1111: ten-bit slave, optional start/stop events.
// - Mode 1000: two-wire master, reload-timed clock.
// - Mode 1011: firmware two-wire master, slave idle.
// - Master buffer write on busy bus collides.
// - Slave buffer write while shifting collides.
// - Start: load rate, both high, drive data.
// - After start, one period, clear start bit.
// - Lines low or clock low aborts start.
// - Buffer write during sequence ignored, collision set.
// - Sequence bits locked until start completes.
// - Acknowledge holds clock low, drives ack bit.
// - Acknowledge: period, release, period, low, idle.
// - Stop: drive data low with clock low.
// - Data low: period, release clock, period, data.
// - Stop seen: flag, then period, event flag.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_A_BUF 8'h00
`define SSP_A_RATE 8'h04
`define SSP_A_STAT 8'h08
`define SSP_A_CON1 8'h0c
`define SSP_A_CON2 8'h10
`define SSP_A_EVT 8'h14
`define SSP_CON1_RST 8'h00
`define SSP_B_WRITE_COLLISION_FLAG 7
`define SSP_B_OV 6
`define SSP_B_EN 5
`define SSP_B_CKP 4
`define SSP_B_ACK_DATA_BIT 5
`define SSP_B_ACK_SEQUENCE_ENABLE 4
`define SSP_B_RCEN 3
`define SSP_B_PEN 2
`define SSP_B_SEN 0
`define SSP_B_STOP 4
`define SSP_B_START 3
`define SSP_B_BF 0
`define SSP_B_IF 0
`define SSP_B_BCOL 1
`define SSP_M_SPI4 4'h0
`define SSP_M_SPI16 4'h1
`define SSP_M_SPI64 4'h2
`define SSP_M_SPIS_SS 4'h4
`define SSP_M_SPIS 4'h5
`define SSP_M_I2CS7 4'h6
`define SSP_M_I2CS10 4'h7
`define SSP_M_I2CM 4'h8
`define SSP_M_I2CFW 4'hb
`define SSP_M_I2CS7I 4'he
`define SSP_M_I2CS10I 4'hf
`define SSP_H4 6'h02
`define SSP_H16 6'h08
`define SSP_H64 6'h20
`endif

/* common/ssp_pkg.sv */
// Types shared by the serial port block.
// Assumes ssp_consts.svh supplies the register and mode constants; the state codes are defined here.
`default_nettype none
package ssp_pkg;
    typedef enum logic [11:0] {
        S_IDLE = 12'h001, S_STW = 12'h002, S_STH = 12'h004, S_ACL = 12'h008,
        S_ACH = 12'h010, S_SPL = 12'h020, S_SPC = 12'h040, S_SPD = 12'h080,
        S_SPW = 12'h100, S_SPE = 12'h200, S_RXL = 12'h400, S_RXH = 12'h800
    } ssp_state_e;
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
        logic sdo;
    } ssp_pins_s;
endpackage : ssp_pkg
`default_nettype wire

/* rtl/ssp_i2c_master.sv */
// Serial port control, SPI shifter and two-wire master sequencer.
// Assumes an APB master, open-drain pin pads outside and 10 MHz i_sys_clk.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_consts.svh"
module ssp_i2c_master (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output ssp_pkg::ssp_pins_s o_pins,
    // Mode and event status
    output logic o_port_owned,
    output logic o_ss_used,
    output logic o_addr10,
    output logic o_ss_irq_en,
    output logic o_event
);
    logic [1:0] pin_raw;
    logic [1:0] pin_s;
    logic scl_s, sda_s;
    ssp_pkg::ssp_state_e st_reg, st_next;
    logic [7:0] buf_reg, rx_sh_reg, spi_sh_reg;
    logic [6:0] rate_reg, brg_reg;
    logic [3:0] mode_reg;
    logic [2:0] rx_cnt_reg;
    logic [4:0] spi_cnt_reg;
    logic [5:0] spi_div_reg, half;
    logic bf_reg, write_collision_flag_reg, ov_reg, en_reg, ckp_reg;
    logic ack_data_bit_reg, ack_sequence_enable_reg, rcen_reg, pen_reg, sen_reg;
    logic start_reg, stop_reg, if_reg, bcol_reg;
    logic scl_drv_reg, sda_drv_reg, scl_next, sda_next;
    logic spi_busy_reg, spi_clk_reg, spi_samp_reg, sck_prev_reg;
    logic acc, wr, rd, wr_buf, wr_con1, wr_con2, wr_evt, rd_buf;
    logic i2cm, i2cs, spim, spis, seq_busy, buf_ok, write_collision_flag_set;
    logic tick, hold, brg_load, spi_edge, spi_done, rx_done, byte_in;
    logic set_start, set_stop, set_bcol, set_if, rx_bit;
    logic clr_sen, clr_ack_sequence_enable, clr_pen, clr_rcen;
    logic [7:0] rx_byte, spi_byte;

    // A change counts only once the second and third stages agree.
    assign pin_raw = {i_sda, i_scl};
    generate
        for (genvar g = 0; g < 2; g++) begin : g_sync
            logic [2:0] sync_reg;
            logic level_reg;
            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    sync_reg <= 3'h7;
                    level_reg <= 1'b1;
                end else begin
                    sync_reg <= {sync_reg[1:0], pin_raw[g]};
                    if (sync_reg[1] == sync_reg[2]) begin
                        level_reg <= sync_reg[2];
                    end
                end
            end
            assign pin_s[g] = level_reg;
        end
    endgenerate
    assign scl_s = pin_s[0];
    assign sda_s = pin_s[1];

    // Mode decode.
    assign spim = en_reg && (mode_reg == `SSP_M_SPI4 || mode_reg == `SSP_M_SPI16 ||
                             mode_reg == `SSP_M_SPI64);
    assign spis = en_reg && (mode_reg == `SSP_M_SPIS || mode_reg == `SSP_M_SPIS_SS);
    assign i2cm = en_reg && (mode_reg == `SSP_M_I2CM || mode_reg == `SSP_M_I2CFW);
    assign i2cs = en_reg && (mode_reg == `SSP_M_I2CS7 || mode_reg == `SSP_M_I2CS10 ||
                             mode_reg == `SSP_M_I2CS7I || mode_reg == `SSP_M_I2CS10I);

    // APB decode; the access completes on the single cycle with pready high.
    assign acc = i_psel && i_penable && o_pready;
    assign wr = acc && i_pwrite;
    assign rd = acc && !i_pwrite;
    assign wr_buf = wr && i_paddr == `SSP_A_BUF;
    assign rd_buf = rd && i_paddr == `SSP_A_BUF;
    assign wr_con1 = wr && i_paddr == `SSP_A_CON1;
    assign wr_con2 = wr && i_paddr == `SSP_A_CON2;
    assign wr_evt = wr && i_paddr == `SSP_A_EVT;

    // Buffer writes are refused while the bus or the shifter is busy.
    assign seq_busy = st_reg != ssp_pkg::S_IDLE || sen_reg || pen_reg || ack_sequence_enable_reg || rcen_reg;
    assign buf_ok = wr_buf && !(i2cm && seq_busy) && !((spim || spis) && spi_busy_reg);
    assign write_collision_flag_set = wr_buf && !buf_ok;

    // Rate generator: held at reload while waiting on a line level.
    assign hold = ((st_reg == ssp_pkg::S_ACH || st_reg == ssp_pkg::S_RXH) && !scl_s) ||
                  st_reg == ssp_pkg::S_SPL || st_reg == ssp_pkg::S_SPW;
    assign tick = st_reg != ssp_pkg::S_IDLE && brg_reg == 7'h00 && !hold;
    assign brg_load = hold || st_next != st_reg;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            brg_reg <= 7'h00;
        end else if (brg_load) begin
            brg_reg <= rate_reg;
        end else if (st_reg != ssp_pkg::S_IDLE) begin
            brg_reg <= (brg_reg == 7'h00) ? rate_reg : brg_reg - 7'h01;
        end
    end

    // Sequencer.
    always_comb begin
        st_next = st_reg;
        scl_next = scl_drv_reg;
        sda_next = sda_drv_reg;
        {set_start, set_stop, set_bcol, set_if, rx_bit, rx_done} = 6'h00;
        {clr_sen, clr_ack_sequence_enable, clr_pen, clr_rcen} = 4'h0;
        case (st_reg)
            ssp_pkg::S_IDLE: begin
                if (sen_reg) begin
                    if (!scl_s && !sda_s) begin
                        set_bcol = 1'b1;
                        clr_sen = 1'b1;
                    end else if (scl_s && sda_s) begin
                        st_next = ssp_pkg::S_STW;
                    end
                end else if (ack_sequence_enable_reg) begin
                    scl_next = 1'b1;
                    sda_next = !ack_data_bit_reg;
                    st_next = ssp_pkg::S_ACL;
                end else if (pen_reg) begin
                    sda_next = 1'b1;
                    st_next = ssp_pkg::S_SPL;
                end else if (rcen_reg) begin
                    scl_next = 1'b1;
                    sda_next = 1'b0;
                    st_next = ssp_pkg::S_RXL;
                end
            end
            ssp_pkg::S_STW: begin
                if (!scl_s || (tick && !sda_s)) begin
                    set_bcol = 1'b1;
                    clr_sen = 1'b1;
                    sda_next = 1'b0;
                    st_next = ssp_pkg::S_IDLE;
                end else if (tick) begin
                    sda_next = 1'b1;
                    set_start = 1'b1;
                    st_next = ssp_pkg::S_STH;
                end
            end
            ssp_pkg::S_STH: begin
                if (tick) begin
                    clr_sen = 1'b1;
                    st_next = ssp_pkg::S_IDLE;
                end
            end
            ssp_pkg::S_ACL: begin
                if (tick) begin
                    scl_next = 1'b0;
                    st_next = ssp_pkg::S_ACH;
                end
            end
            ssp_pkg::S_ACH: begin
                if (tick) begin
                    scl_next = 1'b1;
                    clr_ack_sequence_enable = 1'b1;
                    st_next = ssp_pkg::S_IDLE;
                end
            end
            ssp_pkg::S_SPL: begin
                if (!sda_s) begin
                    st_next = ssp_pkg::S_SPC;
                end
            end
            ssp_pkg::S_SPC: begin
                if (tick) begin
                    scl_next = 1'b0;
                    st_next = ssp_pkg::S_SPD;
                end
            end
            ssp_pkg::S_SPD: begin
                if (tick) begin
                    sda_next = 1'b0;
                    st_next = ssp_pkg::S_SPW;
                end
            end
            ssp_pkg::S_SPW: begin
                if (sda_s && scl_s) begin
                    set_stop = 1'b1;
                    st_next = ssp_pkg::S_SPE;
                end
            end
            ssp_pkg::S_SPE: begin
                if (tick) begin
                    clr_pen = 1'b1;
                    set_if = 1'b1;
                    st_next = ssp_pkg::S_IDLE;
                end
            end
            ssp_pkg::S_RXL: begin
                if (tick) begin
                    scl_next = 1'b0;
                    st_next = ssp_pkg::S_RXH;
                end
            end
            ssp_pkg::S_RXH: begin
                if (tick) begin
                    scl_next = 1'b1;
                    rx_bit = 1'b1;
                    rx_done = rx_cnt_reg == 3'h7;
                    clr_rcen = rx_done;
                    st_next = rx_done ? ssp_pkg::S_IDLE : ssp_pkg::S_RXL;
                end
            end
            default: begin
                st_next = ssp_pkg::S_IDLE;
            end
        endcase
        // Leaving master mode drops the bus at once.
        if (!i2cm) begin
            st_next = ssp_pkg::S_IDLE;
            scl_next = 1'b0;
            sda_next = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= ssp_pkg::S_IDLE;
            scl_drv_reg <= 1'b0;
            sda_drv_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            scl_drv_reg <= scl_next;
            sda_drv_reg <= sda_next;
        end
    end

    // Two-wire receive shifter.
    assign rx_byte = {rx_sh_reg[6:0], sda_s};
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_sh_reg <= 8'h00;
            rx_cnt_reg <= 3'h0;
        end else if (st_reg == ssp_pkg::S_IDLE) begin
            rx_cnt_reg <= 3'h0;
        end else if (rx_bit) begin
            rx_sh_reg <= rx_byte;
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
        end
    end

    // SPI shifter; master clocks from the divider, slave from the clock pin.
    always_comb begin
        case (mode_reg)
            `SSP_M_SPI16: half = `SSP_H16;
            `SSP_M_SPI64: half = `SSP_H64;
            default: half = `SSP_H4;
        endcase
    end
    assign spi_edge = (spim && spi_busy_reg && spi_div_reg == half - 6'h01) ||
                      (spis && scl_s != sck_prev_reg);
    assign spi_done = spi_edge && spi_cnt_reg == 5'h0f;
    assign spi_byte = {spi_sh_reg[6:0], spi_samp_reg};
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            spi_busy_reg <= 1'b0;
            spi_clk_reg <= 1'b0;
            spi_samp_reg <= 1'b0;
            spi_sh_reg <= 8'h00;
            spi_cnt_reg <= 5'h00;
            spi_div_reg <= 6'h00;
            sck_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= scl_s;
            if (!(spim || spis)) begin
                spi_busy_reg <= 1'b0;
                spi_cnt_reg <= 5'h00;
            end else if (buf_ok) begin
                spi_sh_reg <= i_pwdata[7:0];
                spi_busy_reg <= spim;
                spi_cnt_reg <= 5'h00;
                spi_div_reg <= 6'h00;
            end else if (spi_edge) begin
                spi_div_reg <= 6'h00;
                spi_busy_reg <= !spi_done;
                spi_cnt_reg <= spi_done ? 5'h00 : spi_cnt_reg + 5'h01;
                if (spim) begin
                    spi_clk_reg <= !spi_clk_reg;
                end
                if (!spi_cnt_reg[0]) begin
                    spi_samp_reg <= sda_s;
                end else begin
                    spi_sh_reg <= spi_byte;
                end
            end else if (spi_busy_reg) begin
                spi_div_reg <= spi_div_reg + 6'h01;
            end
            // An idle master clock rests at the polarity level.
            if (!spi_busy_reg) begin
                spi_clk_reg <= ckp_reg;
            end
        end
    end

    // Buffer and full flag; a byte that meets a full buffer is dropped.
    assign byte_in = rx_done || spi_done;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            buf_reg <= 8'h00;
            bf_reg <= 1'b0;
        end else begin
            if (buf_ok) begin
                buf_reg <= i_pwdata[7:0];
            end else if (byte_in && !bf_reg) begin
                buf_reg <= rx_done ? rx_byte : spi_byte;
            end
            bf_reg <= byte_in || (bf_reg && !rd_buf);
        end
    end

    // Control one; hardware sets win over software clears.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {write_collision_flag_reg, ov_reg, en_reg, ckp_reg, mode_reg} <= `SSP_CON1_RST;
        end else begin
            write_collision_flag_reg <= write_collision_flag_set || (wr_con1 ? i_pwdata[`SSP_B_WRITE_COLLISION_FLAG] : write_collision_flag_reg);
            ov_reg <= (byte_in && bf_reg && (rx_done || spis)) ||
                      (wr_con1 ? i_pwdata[`SSP_B_OV] : ov_reg);
            if (wr_con1) begin
                en_reg <= i_pwdata[`SSP_B_EN];
                ckp_reg <= i_pwdata[`SSP_B_CKP];
                mode_reg <= i_pwdata[3:0];
            end
        end
    end

    // Control two, rate reload, status and events.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {ack_data_bit_reg, ack_sequence_enable_reg, rcen_reg, pen_reg, sen_reg} <= 5'h00;
            rate_reg <= 7'h00;
        end else begin
            if (wr && i_paddr == `SSP_A_RATE) begin
                rate_reg <= i_pwdata[6:0];
            end
            if (wr_con2) begin
                ack_data_bit_reg <= i_pwdata[`SSP_B_ACK_DATA_BIT];
            end
            // The low sequence bits stay locked while a start is pending.
            if (wr_con2 && !sen_reg) begin
                ack_sequence_enable_reg <= i_pwdata[`SSP_B_ACK_SEQUENCE_ENABLE];
                rcen_reg <= i_pwdata[`SSP_B_RCEN];
                pen_reg <= i_pwdata[`SSP_B_PEN];
                sen_reg <= i_pwdata[`SSP_B_SEN];
            end
            if (clr_sen || !i2cm) sen_reg <= 1'b0;
            if (clr_ack_sequence_enable || !i2cm) ack_sequence_enable_reg <= 1'b0;
            if (clr_pen || !i2cm) pen_reg <= 1'b0;
            if (clr_rcen || !i2cm) rcen_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {start_reg, stop_reg, if_reg, bcol_reg} <= 4'h0;
        end else begin
            start_reg <= en_reg && (set_start || (start_reg && !set_stop));
            stop_reg <= en_reg && (set_stop || (stop_reg && !set_start));
            if_reg <= set_if || byte_in || (wr_evt ? i_pwdata[`SSP_B_IF] : if_reg);
            bcol_reg <= set_bcol || (wr_evt ? i_pwdata[`SSP_B_BCOL] : bcol_reg);
        end
    end

    // APB answer is prepared in the setup cycle, so every access takes two.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            if (i_psel && !i_penable) begin
                o_prdata <= 32'h0000_0000;
                case (i_paddr)
                    `SSP_A_BUF: o_prdata[7:0] <= buf_reg;
                    `SSP_A_RATE: o_prdata[6:0] <= rate_reg;
                    `SSP_A_STAT: o_prdata[7:0] <= {3'h0, stop_reg, start_reg, 2'h0, bf_reg};
                    `SSP_A_CON1: o_prdata[7:0] <= {write_collision_flag_reg, ov_reg, en_reg, ckp_reg, mode_reg};
                    `SSP_A_CON2: o_prdata[7:0] <= {2'h0, ack_data_bit_reg, ack_sequence_enable_reg, rcen_reg,
                                                   pen_reg, 1'b0, sen_reg};
                    `SSP_A_EVT: o_prdata[1:0] <= {bcol_reg, if_reg};
                    default: o_pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Pin ownership and drive; two-wire lines are open drain, drive means low.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pins <= '0;
            {o_port_owned, o_ss_used, o_addr10, o_ss_irq_en, o_event} <= 5'h00;
        end else begin
            o_pins <= '0;
            o_port_owned <= en_reg;
            o_ss_used <= en_reg && mode_reg == `SSP_M_SPIS_SS;
            o_addr10 <= en_reg && (mode_reg == `SSP_M_I2CS10 ||
                                   mode_reg == `SSP_M_I2CS10I);
            o_ss_irq_en <= en_reg && mode_reg == `SSP_M_I2CS10I;
            o_event <= if_reg;
            if (spim) begin
                o_pins.scl_o <= spi_clk_reg;
                o_pins.scl_oe <= 1'b1;
                o_pins.sdo <= spi_sh_reg[7];
            end else if (spis) begin
                o_pins.sdo <= spi_sh_reg[7];
            end else if (i2cs) begin
                o_pins.scl_oe <= !ckp_reg;
            end else if (i2cm) begin
                o_pins.scl_oe <= scl_drv_reg;
                o_pins.sda_oe <= sda_drv_reg;
            end
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    AST_START: assert property (st_reg == ssp_pkg::S_STW && tick && scl_s && sda_s && i2cm
        |=> start_reg && sda_drv_reg ##1 o_pins.sda_oe) else $error("start not driven");
    AST_HOLD: assert property (st_reg == ssp_pkg::S_STH && tick && i2cm
        |=> !sen_reg && st_reg == ssp_pkg::S_IDLE && sda_drv_reg) else $error("start end bad");
    AST_BCOL: assert property (st_reg == ssp_pkg::S_STW && !scl_s && i2cm
        |=> bcol_reg && st_reg == ssp_pkg::S_IDLE) else $error("collision not flagged");
    AST_WRITE_COLLISION_FLAG: assert property (wr_buf && i2cm && st_reg != ssp_pkg::S_IDLE
        |=> write_collision_flag_reg && buf_reg == $past(buf_reg)) else $error("busy write accepted");
    AST_LOCK: assert property (wr_con2 && sen_reg && i2cm
        |=> pen_reg == $past(pen_reg) && ack_sequence_enable_reg == $past(ack_sequence_enable_reg)) else $error("lock broken");
    AST_ACK: assert property (st_reg == ssp_pkg::S_IDLE && i2cm && !sen_reg && ack_sequence_enable_reg
        |=> scl_drv_reg && sda_drv_reg == !ack_data_bit_reg) else $error("ack drive wrong");
    AST_STOPIF: assert property (st_reg == ssp_pkg::S_SPE && tick && i2cm
        |=> if_reg && !pen_reg) else $error("stop end bad");
    AST_OV: assert property (rx_done && bf_reg |=> ov_reg) else $error("overflow missed");
    AST_EN: assert property (!en_reg |=> !o_pins.scl_oe && !o_pins.sda_oe && !o_port_owned)
        else $error("pins driven while off");
    AST_STRETCH: assert property (i2cs && !ckp_reg |=> o_pins.scl_oe)
        else $error("clock not stretched");
    AST_IDLECK: assert property ((spim && !spi_busy_reg && $stable(ckp_reg))[*3]
        |-> o_pins.scl_o == ckp_reg) else $error("spi idle level");
    CV_START: cover property (set_start);
    CV_STOP: cover property (set_if);
    CV_SPI: cover property (spi_done);
endmodule : ssp_i2c_master
`default_nettype wire

/* tb/ssp_bus_peer.sv */
// Two-wire bus peer: pull-ups on both lines and a peer that can hold either line low.
// Assumes the port only drives open-drain enables onto the lines.
`timescale 1ns/100ps
`default_nettype none
module ssp_bus_peer (
    // Port side
    input wire logic i_scl_oe,
    input wire logic i_sda_oe,
    // Peer control
    input wire logic i_hold_scl,
    input wire logic i_hold_sda,
    // Wire levels
    output logic o_scl,
    output logic o_sda
);
    // A released line floats high through its pull-up.
    assign o_scl = !(i_scl_oe || i_hold_scl);
    assign o_sda = !(i_sda_oe || i_hold_sda);
endmodule : ssp_bus_peer
`default_nettype wire

/* tb/ssp_i2c_master_tb.sv */
// Bench for the serial port block: APB register tests and two-wire sequences.
// Assumes the bus peer model and a 10 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_consts.svh"
module ssp_i2c_master_tb;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, stop_enable_bit = 1'b0, pwr = 1'b0;
    logic hs = 1'b0, hd = 1'b0, pready, perr, re, scl, sda, own, ssu, a10, ssie, evt;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [3:0] md [4] = '{4'h4, 4'h5, 4'h7, 4'hf};
    logic [3:0] mx [4] = '{4'b0100, 4'b0000, 4'b1010, 4'b1011};
    ssp_pkg::ssp_pins_s pins;
    int miscompares = 0, checks = 0, cyc = 0;
    ssp_i2c_master u_ssp_i2c_master (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel),
        .i_penable(stop_enable_bit), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(pready), .o_pslverr(perr), .i_scl(scl), .i_sda(sda), .o_pins(pins),
        .o_port_owned(own), .o_ss_used(ssu), .o_addr10(a10), .o_ss_irq_en(ssie),
        .o_event(evt));
    ssp_bus_peer u_ssp_bus_peer (.i_scl_oe(pins.scl_oe), .i_sda_oe(pins.sda_oe),
        .i_hold_scl(hs), .i_hold_sda(hd), .o_scl(scl), .o_sda(sda));
    initial begin
        forever #50 clk = ~clk;
    end
    // The whole run needs well under a thousand cycles; this ceiling only catches hangs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        stop_enable_bit <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prd;
        re = perr;
        psel <= 1'b0;
        stop_enable_bit <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        apb(1'b0, a, 32'h0);
        while (((rd & m) !== v) && n < 300) begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        chk(rd & m, v);
    endtask : rdchk
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rdchk(`SSP_A_CON1, 32'hff, `SSP_CON1_RST);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, re}, 32'h1);
        apb(1'b1, `SSP_A_CON1, 32'h30);
        repeat (3) @(posedge clk);
        chk({31'h0, pins.scl_o}, 32'h1);
        apb(1'b1, `SSP_A_CON1, 32'h20);
        repeat (3) @(posedge clk);
        chk({31'h0, pins.scl_o}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `SSP_A_CON1, {28'h2, md[i]});
            repeat (2) @(posedge clk);
            chk({28'h0, pins.scl_oe, ssu, a10, ssie}, {28'h0, mx[i]});
        end
        apb(1'b1, `SSP_A_CON1, 32'h28);
        apb(1'b1, `SSP_A_RATE, 32'h7);
        repeat (2) @(posedge clk);
        chk({31'h0, own}, 32'h1);
        apb(1'b1, `SSP_A_CON2, 32'h1);
        apb(1'b1, `SSP_A_BUF, 32'h55);
        apb(1'b1, `SSP_A_CON2, 32'h10);
        rdchk(`SSP_A_CON2, 32'h1, 32'h0);
        chk(rd & 32'h10, 32'h0);
        chk({31'h0, pins.sda_oe}, 32'h1);
        rdchk(`SSP_A_STAT, 32'h08, 32'h08);
        rdchk(`SSP_A_CON1, 32'h80, 32'h80);
        rdchk(`SSP_A_BUF, 32'hff, 32'h0);
        apb(1'b1, `SSP_A_CON1, 32'h28);
        apb(1'b1, `SSP_A_CON2, 32'h10);
        repeat (3) @(posedge clk);
        chk({30'h0, pins.scl_oe, pins.sda_oe}, 32'h3);
        rdchk(`SSP_A_CON2, 32'h10, 32'h0);
        chk({31'h0, pins.scl_oe}, 32'h1);
        apb(1'b1, `SSP_A_CON2, 32'h4);
        rdchk(`SSP_A_CON2, 32'h4, 32'h0);
        chk({30'h0, pins.scl_oe, pins.sda_oe}, 32'h0);
        rdchk(`SSP_A_STAT, 32'h10, 32'h10);
        rdchk(`SSP_A_EVT, 32'h1, 32'h1);
        chk({31'h0, evt}, 32'h1);
        apb(1'b1, `SSP_A_EVT, 32'h0);
        hs <= 1'b1;
        hd <= 1'b1;
        repeat (8) @(posedge clk);
        apb(1'b1, `SSP_A_CON2, 32'h1);
        rdchk(`SSP_A_EVT, 32'h2, 32'h2);
        rdchk(`SSP_A_CON2, 32'h1, 32'h0);
        hs <= 1'b0;
        hd <= 1'b0;
        apb(1'b1, `SSP_A_EVT, 32'h0);
        repeat (8) @(posedge clk);
        // Clock pulled low by the peer while the start waits out its period.
        apb(1'b1, `SSP_A_CON2, 32'h1);
        hs <= 1'b1;
        rdchk(`SSP_A_EVT, 32'h2, 32'h2);
        rdchk(`SSP_A_STAT, 32'h08, 32'h0);
        hs <= 1'b0;
        // Two bytes of all ones in a row; the second meets a full buffer.
        apb(1'b1, `SSP_A_CON2, 32'h8);
        rdchk(`SSP_A_CON2, 32'h8, 32'h0);
        apb(1'b1, `SSP_A_CON2, 32'h8);
        rdchk(`SSP_A_CON1, 32'h40, 32'h40);
        rdchk(`SSP_A_BUF, 32'hff, 32'hff);
        apb(1'b1, `SSP_A_CON1, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, own}, 32'h0);
        stop_test();
    end
endmodule : ssp_i2c_master_tb
`default_nettype wire
